// ---- design/cid_defines.svh ----
// Shared constants for the caller ID line monitor control blocks.
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH
`define CLK_PERIOD_NS 40
`define CYC(ns)       (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FRAME_NS      125000
`define FRAME_CYC     `CYC(`FRAME_NS)
`define OHC_00_NS     256000000
`define OHC_DEF_NS    390750000
`define OHC_10_NS     128000000
`define OHC_FAST_NS   8000000
`define CAL_NS        8000000
`define RCAL_NS       4000000
`define REV_WAIT_NS   40000000
`define SAMPLE_W      16
`define LVS_W         8
`define REG_CTRL      4'h0
`define REG_STATUS    4'h1
`define REG_RXDATA    4'h2
`define REG_INT_STAT  4'h3
`define REG_INT_CLR   4'h4
`define REG_INT_EN    4'h5
`define REG_LVS_MIN   4'h6
`define CTRL_RESET    8'h40
`define BIT_OFFHOOK   0
`define BIT_FULLWAVE  1
`define BIT_CALDIS    2
`define BIT_MONITOR   3
`define BIT_MUTE      4
`define BIT_RCALDIS   5
`define FLD_CNTSEL_LO 6
`define FLD_CNTSEL_HI 7
`define INT_W         6
`define INT_RING_POS  0
`define INT_RING_NEG  1
`define INT_RINGING   2
`define INT_REVERSAL  3
`define INT_SAMPLE    4
`define INT_LOW_LINE  5
`endif

// ---- design/cid_pkg.sv ----
// Types shared by both ends of the caller ID line monitor link.
package cid_pkg;
   typedef enum logic [4:0] {
      ST_ONHOOK = 5'h01,
      ST_COUNT  = 5'h02,
      ST_CAL    = 5'h04,
      ST_RCAL   = 5'h08,
      ST_OPEN   = 5'h10
   } hook_state_t;
   typedef enum logic [1:0] {
      CL_IDLE = 2'h1,
      CL_WAIT = 2'h2
   } classify_state_t;
endpackage

// ---- design/cid_link_if.sv ----
// Link between the line monitor device and its host controller.
`timescale 1ns/10ps
`include "cid_defines.svh"
interface cid_link_if;
   logic              offhook_control;
   logic              onhook_monitor_enable;
   logic              fullwave_ring_detect_enable;
   logic              calibration_disable;
   logic              resistor_calibration_disable;
   logic [1:0]        offhook_counter_select;
   logic              receive_mute;
   logic              ring_detect_positive;
   logic              ring_detect_negative;
   logic [`LVS_W-1:0] line_voltage_status;
   logic              path_open;
   logic              frame_sync;
   logic              transmit_data_highway_pin;
   logic              transmit_data_drive;
   modport device (
      input  offhook_control, onhook_monitor_enable, fullwave_ring_detect_enable,
      input  calibration_disable, resistor_calibration_disable, offhook_counter_select, receive_mute,
      output ring_detect_positive, ring_detect_negative, line_voltage_status, path_open,
      output frame_sync, transmit_data_highway_pin, transmit_data_drive
   );
   modport host (
      output offhook_control, onhook_monitor_enable, fullwave_ring_detect_enable,
      output calibration_disable, resistor_calibration_disable, offhook_counter_select, receive_mute,
      input  ring_detect_positive, ring_detect_negative, line_voltage_status, path_open,
      input  frame_sync, transmit_data_highway_pin, transmit_data_drive
   );
endinterface

// ---- design/pin_sync.sv ----
// Three-stage pin synchroniser.
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 2
) (
   input  wire logic         i_clock,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_level
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;
   logic [W-1:0] lvl_d;

   if (W < 1) $error("pin_sync width must be at least one");

   // A bit changes once stages two and three agree.
   for (genvar g = 0; g < W; g++) begin : g_bit
      always_comb begin
         lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
      end
   end

   // Stage one feeds stage two only.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_q <= '0;
      end else begin
         s1_q  <= i_pin;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign o_level = lvl_q;
endmodule

// ---- design/cid_device_end.sv ----
// Device end: hook sequencing, ring flags and the highway.
//
// Overview of operation
// - Monitor bit on: on-hook samples reach highway.
// - Host sets monitor after first ring, clears after.
// - Host enables full-wave detection first.
// - Reversal raises positive or negative ring flag.
// - Host waits 40 ms to classify ring edges.
// - Calibration-disable skips off-hook calibration.
// - Resistor-calibration-disable skips resistor calibration.
// - Counter select 11 gives 8 ms, 01 default.
// - Off-hook bit clear means on-hook, set off-hook.
// - Receive mute silences data toward host.
// - Data blocked until counter and calibrations finish.
// - On-hook without monitor: highway pin stays undriven.
// - Host reads line voltage, abandons if low.
// - Host prepares fast re-hook first.
// - Host may restore default calibration and counter.
`timescale 1ns/10ps
`include "cid_defines.svh"
module cid_device_end
   import cid_pkg::*;
#(
   parameter int unsigned OHC_00_CYC   = `CYC(`OHC_00_NS),
   parameter int unsigned OHC_DEF_CYC  = `CYC(`OHC_DEF_NS),
   parameter int unsigned OHC_10_CYC   = `CYC(`OHC_10_NS),
   parameter int unsigned OHC_FAST_CYC = `CYC(`OHC_FAST_NS),
   parameter int unsigned CAL_CYC      = `CYC(`CAL_NS),
   parameter int unsigned RCAL_CYC     = `CYC(`RCAL_NS),
   parameter int unsigned FRAME_CYC    = `FRAME_CYC,
   parameter int unsigned SAMPLE_W     = `SAMPLE_W
) (
   input  wire logic                i_clock,
   input  wire logic                i_rst,
   cid_link_if.device               link,
   input  wire logic                i_ring_pos_pin,
   input  wire logic                i_ring_neg_pin,
   input  wire logic [SAMPLE_W-1:0] i_line_sample,
   input  wire logic [`LVS_W-1:0]   i_line_voltage,
   output logic                     o_hook_relay,
   output logic                     o_cal_busy,
   output logic                     o_rcal_busy,
   output logic                     o_tx_gate
);
   localparam int unsigned CW = 32;
   localparam int unsigned BW = $clog2(SAMPLE_W + 1);
   localparam int unsigned FW = $clog2(FRAME_CYC);

   if (FRAME_CYC < SAMPLE_W + 2) $error("frame too short for one sample");
   if (SAMPLE_W < 2) $error("sample width must be at least two");
   if (OHC_FAST_CYC < 1 || CAL_CYC < 1 || RCAL_CYC < 1) $error("timer counts must be nonzero");

   hook_state_t   st_q;
   hook_state_t   st_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic [CW-1:0] ohc_load;

   logic [1:0]    ring_lvl;
   logic [1:0]    ring_prev_q;
   logic [1:0]    ring_prev_d;
   logic          rpos_q;
   logic          rpos_d;
   logic          rneg_q;
   logic          rneg_d;
   logic [`LVS_W-1:0] lvs_q;

   logic [FW-1:0]       fcnt_q;
   logic [FW-1:0]       fcnt_d;
   logic [SAMPLE_W-1:0] sh_q;
   logic [SAMPLE_W-1:0] sh_d;
   logic [BW-1:0]       bits_q;
   logic [BW-1:0]       bits_d;
   logic                fs_q;
   logic                fs_d;
   logic                dtx_q;
   logic                dtx_d;
   logic                drv_q;
   logic                drv_d;
   logic                send_ok;

   // Asynchronous ring pins are synchronised.
   pin_sync #(
      .W (2)
   ) u_ring_sync (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_pin   ({i_ring_neg_pin, i_ring_pos_pin}),
      .o_level (ring_lvl)
   );

   // Settling time chosen by the counter select field.
   always_comb begin
      case (link.offhook_counter_select)
         2'h0:    ohc_load = CW'(OHC_00_CYC);
         2'h1:    ohc_load = CW'(OHC_DEF_CYC);
         2'h2:    ohc_load = CW'(OHC_10_CYC);
         default: ohc_load = CW'(OHC_FAST_CYC);
      endcase
   end

   // Hook sequencer: counter, then calibration, then resistor calibration.
   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_ONHOOK: begin
            if (link.offhook_control) begin
               st_d  = ST_COUNT;
               cnt_d = ohc_load - CW'(1);
            end
         end
         ST_COUNT, ST_CAL, ST_RCAL: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - CW'(1);
            end else if (st_q == ST_COUNT && !link.calibration_disable) begin
               st_d  = ST_CAL;
               cnt_d = CW'(CAL_CYC) - CW'(1);
            end else if (st_q != ST_RCAL && !link.resistor_calibration_disable) begin
               st_d  = ST_RCAL;
               cnt_d = CW'(RCAL_CYC) - CW'(1);
            end else begin
               st_d  = ST_OPEN;
            end
         end
         ST_OPEN: begin
            st_d = ST_OPEN;
         end
         default: begin
            st_d  = ST_ONHOOK;
            cnt_d = '0;
         end
      endcase
      // Clearing the hook bit always returns on-hook at once.
      if (!link.offhook_control) begin
         st_d  = ST_ONHOOK;
         cnt_d = '0;
      end
   end

   // Hook sequencer registers.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_q  <= ST_ONHOOK;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // A rising threshold crossing raises a one-cycle ring flag.
   // Half-wave detection only sees the positive threshold.
   always_comb begin
      ring_prev_d = ring_lvl;
      rpos_d      = ring_lvl[0] & ~ring_prev_q[0];
      rneg_d      = ring_lvl[1] & ~ring_prev_q[1] & link.fullwave_ring_detect_enable;
   end

   // Ring flags and line voltage registers.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ring_prev_q <= '0;
         rpos_q      <= 1'b0;
         rneg_q      <= 1'b0;
         lvs_q       <= '0;
      end else begin
         ring_prev_q <= ring_prev_d;
         rpos_q      <= rpos_d;
         rneg_q      <= rneg_d;
         lvs_q       <= i_line_voltage;
      end
   end

   // Samples go out when fully off-hook, or on-hook with monitoring on.
   assign send_ok = (st_q == ST_OPEN) ||
                    ((st_q == ST_ONHOOK) && link.onhook_monitor_enable);

   // Highway framing: one sync per frame, then the sample MSB first.
   always_comb begin
      fcnt_d = (fcnt_q == FW'(FRAME_CYC - 1)) ? '0 : fcnt_q + FW'(1);
      fs_d   = (fcnt_q == '0);
      sh_d   = sh_q;
      bits_d = bits_q;
      dtx_d  = 1'b0;
      drv_d  = 1'b0;
      if (fcnt_q == '0) begin
         // Same slot and format whether on-hook monitoring or off-hook.
         sh_d   = link.receive_mute ? '0 : i_line_sample;
         bits_d = BW'(SAMPLE_W);
      end else if (bits_q != '0) begin
         // Drive starts only with the first slot bit, so no slot starts part way through.
         drv_d  = send_ok & (drv_q | (bits_q == BW'(SAMPLE_W)));
         dtx_d  = drv_d & sh_q[SAMPLE_W-1];
         sh_d   = {sh_q[SAMPLE_W-2:0], 1'b0};
         bits_d = bits_q - BW'(1);
      end
   end

   // Highway registers.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         fcnt_q <= '0;
         sh_q   <= '0;
         bits_q <= '0;
         fs_q   <= 1'b0;
         dtx_q  <= 1'b0;
         drv_q  <= 1'b0;
      end else begin
         fcnt_q <= fcnt_d;
         sh_q   <= sh_d;
         bits_q <= bits_d;
         fs_q   <= fs_d;
         dtx_q  <= dtx_d;
         drv_q  <= drv_d;
      end
   end

   // Link outputs from flip-flops; path_open is decoded from the state register.
   assign link.ring_detect_positive      = rpos_q;
   assign link.ring_detect_negative      = rneg_q;
   assign link.line_voltage_status       = lvs_q;
   assign link.path_open                 = (st_q == ST_OPEN);
   assign link.frame_sync                = fs_q;
   assign link.transmit_data_highway_pin = dtx_q;
   assign link.transmit_data_drive       = drv_q;

   // Line-side controls follow the sequencer state.
   assign o_hook_relay = (st_q != ST_ONHOOK);
   assign o_cal_busy   = (st_q == ST_CAL);
   assign o_rcal_busy  = (st_q == ST_RCAL);
   assign o_tx_gate    = (st_q == ST_OPEN);
endmodule

// ---- design/cid_host_end.sv ----
// Host end: registers, highway receiver, ring classifier, interrupt.
`timescale 1ns/10ps
`include "cid_defines.svh"
module cid_host_end
   import cid_pkg::*;
#(
   parameter int unsigned REV_WAIT_CYC = `CYC(`REV_WAIT_NS),
   parameter int unsigned SAMPLE_W     = `SAMPLE_W
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   cid_link_if.host         link,
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   output logic             o_irq
);
   localparam int unsigned BW = $clog2(SAMPLE_W + 1);

   if (SAMPLE_W > 16 || SAMPLE_W < 2) $error("sample must fit the 16-bit data port");
   if (REV_WAIT_CYC < 1) $error("reversal wait must be nonzero");

   logic [7:0]          ctrl_q;
   logic [7:0]          ctrl_d;
   logic [`LVS_W-1:0]   lvmin_q;
   logic [`LVS_W-1:0]   lvmin_d;
   logic [`INT_W-1:0]   stat_q;
   logic [`INT_W-1:0]   stat_d;
   logic [`INT_W-1:0]   en_q;
   logic [`INT_W-1:0]   en_d;
   logic [`INT_W-1:0]   ev;
   logic [15:0]         rd_q;
   logic [15:0]         rd_d;
   classify_state_t     cl_q;
   classify_state_t     cl_d;
   logic [31:0]         tmr_q;
   logic [31:0]         tmr_d;
   logic [SAMPLE_W-1:0] rsh_q;
   logic [SAMPLE_W-1:0] rsh_d;
   logic [SAMPLE_W-1:0] rx_q;
   logic [SAMPLE_W-1:0] rx_d;
   logic [BW-1:0]       rcnt_q;
   logic [BW-1:0]       rcnt_d;
   logic                good_q;
   logic                good_d;
   logic                edge_seen;

   assign edge_seen = link.ring_detect_positive | link.ring_detect_negative;

   // Next-state logic of the host.
   always_comb begin
      ctrl_d  = ctrl_q;
      lvmin_d = lvmin_q;
      en_d    = en_q;
      cl_d    = cl_q;
      tmr_d   = tmr_q;
      rsh_d   = rsh_q;
      rx_d    = rx_q;
      rcnt_d  = rcnt_q;
      good_d  = good_q;
      ev      = '0;
      ev[`INT_RING_POS] = link.ring_detect_positive;
      ev[`INT_RING_NEG] = link.ring_detect_negative;
      // Line voltage below the floor while on-hook means a parallel set.
      ev[`INT_LOW_LINE] = ~ctrl_q[`BIT_OFFHOOK] & (link.line_voltage_status < lvmin_q);
      // A second edge inside the wait means ringing, none means reversal.
      case (cl_q)
         CL_IDLE: begin
            if (edge_seen) begin
               cl_d  = CL_WAIT;
               tmr_d = REV_WAIT_CYC - 32'd1;
            end
         end
         CL_WAIT: begin
            if (edge_seen) begin
               cl_d             = CL_IDLE;
               ev[`INT_RINGING] = 1'b1;
            end else if (tmr_q == '0) begin
               cl_d              = CL_IDLE;
               ev[`INT_REVERSAL] = 1'b1;
            end else begin
               tmr_d = tmr_q - 32'd1;
            end
         end
         default: begin
            cl_d = CL_IDLE;
         end
      endcase
      // Sample capture, MSB first after the frame sync.
      if (link.frame_sync) begin
         rcnt_d = BW'(SAMPLE_W);
         good_d = 1'b1;
      end else if (rcnt_q != '0) begin
         rsh_d  = {rsh_q[SAMPLE_W-2:0], link.transmit_data_highway_pin};
         good_d = good_q & link.transmit_data_drive;
         rcnt_d = rcnt_q - BW'(1);
         if (rcnt_q == BW'(1) && good_d) begin
            rx_d            = rsh_d;
            ev[`INT_SAMPLE] = 1'b1;
         end
      end
      if (i_wr && i_addr == `REG_CTRL) begin
         ctrl_d = i_wdata[7:0];
      end
      if (i_wr && i_addr == `REG_INT_EN) begin
         en_d = i_wdata[`INT_W-1:0];
      end
      if (i_wr && i_addr == `REG_LVS_MIN) begin
         lvmin_d = i_wdata[`LVS_W-1:0];
      end
      // A new event wins over a clear in the same cycle.
      stat_d = stat_q;
      if (i_wr && i_addr == `REG_INT_CLR) begin
         stat_d = stat_q & ~i_wdata[`INT_W-1:0];
      end
      stat_d = stat_d | ev;
      rd_d = '0;
      if (i_rd) begin
         case (i_addr)
            `REG_CTRL:     rd_d = {8'h00, ctrl_q};
            `REG_STATUS:   rd_d = {link.line_voltage_status, 6'h00, link.path_open, cl_q == CL_WAIT};
            `REG_RXDATA:   rd_d = 16'(rx_q);
            `REG_INT_STAT: rd_d = 16'(stat_q);
            `REG_INT_EN:   rd_d = 16'(en_q);
            `REG_LVS_MIN:  rd_d = 16'(lvmin_q);
            default:       rd_d = '0;
         endcase
      end
   end

   // Host state registers.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ctrl_q  <= `CTRL_RESET;
         lvmin_q <= '0;
         stat_q  <= '0;
         en_q    <= '0;
         rd_q    <= '0;
         cl_q    <= CL_IDLE;
         tmr_q   <= '0;
         rsh_q   <= '0;
         rx_q    <= '0;
         rcnt_q  <= '0;
         good_q  <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         lvmin_q <= lvmin_d;
         stat_q  <= stat_d;
         en_q    <= en_d;
         rd_q    <= rd_d;
         cl_q    <= cl_d;
         tmr_q   <= tmr_d;
         rsh_q   <= rsh_d;
         rx_q    <= rx_d;
         rcnt_q  <= rcnt_d;
         good_q  <= good_d;
      end
   end

   // Control bits come straight from the control register.
   assign link.offhook_control              = ctrl_q[`BIT_OFFHOOK];
   assign link.fullwave_ring_detect_enable  = ctrl_q[`BIT_FULLWAVE];
   assign link.calibration_disable          = ctrl_q[`BIT_CALDIS];
   assign link.onhook_monitor_enable        = ctrl_q[`BIT_MONITOR];
   assign link.receive_mute                 = ctrl_q[`BIT_MUTE];
   assign link.resistor_calibration_disable = ctrl_q[`BIT_RCALDIS];
   assign link.offhook_counter_select       = ctrl_q[`FLD_CNTSEL_HI:`FLD_CNTSEL_LO];
   assign o_rdata = rd_q;
   assign o_irq   = |(stat_q & en_q);
endmodule

// ---- tb/cid_link_chk.sv ----
// Checker of the link between the two ends.
`timescale 1ns/10ps
module cid_link_chk #(
   parameter int OHC_FAST_CYC = 20,
   parameter int FRAME_CYC    = 40
) (
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   input  wire logic       offhook_control,
   input  wire logic       onhook_monitor_enable,
   input  wire logic       fullwave_ring_detect_enable,
   input  wire logic       calibration_disable,
   input  wire logic       resistor_calibration_disable,
   input  wire logic [1:0] offhook_counter_select,
   input  wire logic       receive_mute,
   input  wire logic       ring_detect_positive,
   input  wire logic       ring_detect_negative,
   input  wire logic       path_open,
   input  wire logic       frame_sync,
   input  wire logic       transmit_data_highway_pin,
   input  wire logic       transmit_data_drive
);
   logic [7:0] on_cnt_q;
   logic [7:0] blk_cnt_q;
   logic [7:0] mute_cnt_q;
   logic       blk;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Blocked: path closed and no on-hook monitoring.
   assign blk = !path_open && !(onhook_monitor_enable && !offhook_control);
   // Saturating counts of consecutive cycles off-hook, blocked and muted.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         on_cnt_q   <= 8'h00;
         blk_cnt_q  <= 8'h00;
         mute_cnt_q <= 8'h00;
      end else begin
         on_cnt_q   <= !offhook_control ? 8'h00 : on_cnt_q + 8'(on_cnt_q != 8'hFF);
         blk_cnt_q  <= !blk ? 8'h00 : blk_cnt_q + 8'(blk_cnt_q != 8'hFF);
         mute_cnt_q <= !receive_mute ? 8'h00 : mute_cnt_q + 8'(mute_cnt_q != 8'hFF);
      end
   end
   property p_pin_quiet; !transmit_data_drive |-> !transmit_data_highway_pin; endproperty
   a_pin_quiet: assert property (p_pin_quiet) else $error("data while undriven");
   property p_blocked; blk_cnt_q >= 8'h14 |-> !transmit_data_drive; endproperty
   a_blocked: assert property (p_blocked) else $error("driven while blocked");
   property p_hook_fast;
      $rose(path_open) && offhook_counter_select == 2'h3 && calibration_disable && resistor_calibration_disable
         |-> on_cnt_q >= OHC_FAST_CYC && on_cnt_q <= OHC_FAST_CYC + 4;
   endproperty
   a_hook_fast: assert property (p_hook_fast) else $error("fast count wrong");
   property p_onhook_closed; !offhook_control |=> !path_open; endproperty
   a_onhook_closed: assert property (p_onhook_closed) else $error("open while on-hook");
   property p_neg_fullwave; ring_detect_negative |-> fullwave_ring_detect_enable; endproperty
   a_neg_fullwave: assert property (p_neg_fullwave) else $error("negative flag in half wave");
   property p_ring_pulse;
      ring_detect_positive || ring_detect_negative |=> !ring_detect_positive && !ring_detect_negative;
   endproperty
   a_ring_pulse: assert property (p_ring_pulse) else $error("ring flag too long");
   property p_frame_period; frame_sync |-> ##FRAME_CYC frame_sync; endproperty
   a_frame_period: assert property (p_frame_period) else $error("frame period wrong");
   property p_slot_after_sync; $rose(transmit_data_drive) |-> $past(frame_sync); endproperty
   a_slot_after_sync: assert property (p_slot_after_sync) else $error("slot not after sync");
   property p_monitor_drive;
      frame_sync && onhook_monitor_enable && !offhook_control && $past(onhook_monitor_enable, 2)
         && !$past(offhook_control, 2) |=> transmit_data_drive [*8];
   endproperty
   a_monitor_drive: assert property (p_monitor_drive) else $error("monitor not driven");
   property p_mute_zero; mute_cnt_q >= FRAME_CYC + 20 |-> !transmit_data_highway_pin; endproperty
   a_mute_zero: assert property (p_mute_zero) else $error("data while muted");
endmodule

// ---- tb/caller_id_line_monitor_control_bench.sv ----
// Testbench of both ends over the link.
`timescale 1ns/10ps
`include "cid_defines.svh"
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module caller_id_line_monitor_control_bench;
   localparam int FAST = 20;
   localparam int FRAME = 40;
   localparam int REV = 100;
   logic        i_clock = 1'b0;
   logic        i_rst = 1'b1;
   logic [3:0]  i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [15:0] o_rdata;
   logic        o_irq;
   logic        ring_pos = 1'b0;
   logic        ring_neg = 1'b0;
   logic [15:0] sample = 16'hA5C3;
   logic [7:0]  volt = 8'hC8;
   logic [15:0] rd_q;
   logic [15:0] word;
   logic        drv_all;
   logic        drv_any;
   logic [1:0]  pins;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          base;
   int          t;
   int          cnt_tab [4] = '{40, 50, 30, 20};
   cid_link_if link ();
   cid_device_end #(.OHC_00_CYC(40), .OHC_DEF_CYC(50), .OHC_10_CYC(30), .OHC_FAST_CYC(FAST), .CAL_CYC(10),
      .RCAL_CYC(5), .FRAME_CYC(FRAME)) u_cid_device_end (.i_clock(i_clock), .i_rst(i_rst), .link(link.device),
      .i_ring_pos_pin(ring_pos), .i_ring_neg_pin(ring_neg), .i_line_sample(sample), .i_line_voltage(volt),
      .o_hook_relay(pins[1]), .o_cal_busy(), .o_rcal_busy(), .o_tx_gate(pins[0]));
   cid_host_end #(.REV_WAIT_CYC(REV)) u_cid_host_end (.i_clock(i_clock), .i_rst(i_rst), .link(link.host),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
   cid_link_chk #(.OHC_FAST_CYC(FAST), .FRAME_CYC(FRAME)) u_cid_link_chk (.i_clock(i_clock), .i_rst(i_rst),
      .offhook_control(link.offhook_control), .onhook_monitor_enable(link.onhook_monitor_enable),
      .fullwave_ring_detect_enable(link.fullwave_ring_detect_enable),
      .calibration_disable(link.calibration_disable),
      .resistor_calibration_disable(link.resistor_calibration_disable),
      .offhook_counter_select(link.offhook_counter_select), .receive_mute(link.receive_mute),
      .ring_detect_positive(link.ring_detect_positive), .ring_detect_negative(link.ring_detect_negative),
      .path_open(link.path_open), .frame_sync(link.frame_sync),
      .transmit_data_highway_pin(link.transmit_data_highway_pin), .transmit_data_drive(link.transmit_data_drive));
   // Free-running 25 MHz clock.
   always #20 i_clock = ~i_clock;
   // One-cycle register write.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   // One-cycle register read; data taken the cycle after.
   task automatic rd(input logic [3:0] a);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 rd_q = o_rdata;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // Waits for a frame sync and shifts in the slot.
   task automatic grab;
      int k;
      k = 0;
      @(posedge i_clock);
      #1;
      while (link.frame_sync !== 1'b1 && k < 2 * FRAME) begin
         @(posedge i_clock);
         #1;
         k++;
      end
      drv_all = 1'b1;
      drv_any = 1'b0;
      for (int b = 0; b < 16; b++) begin
         @(posedge i_clock);
         #1;
         word = {word[14:0], link.transmit_data_highway_pin};
         drv_all &= link.transmit_data_drive;
         drv_any |= link.transmit_data_drive;
      end
   endtask
   // Goes off-hook with settings c and counts cycles to open.
   task automatic hook(input logic [15:0] c);
      wr(`REG_CTRL, c);
      wr(`REG_CTRL, c | 16'h0001);
      #1 t = 0;
      while (link.path_open !== 1'b1 && t < 500) begin
         @(posedge i_clock);
         t++;
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #(40000 * 40);
      fail_count++;
      end_of_test();
   end
   // Main sequence of tests.
   initial begin
      idle(20);
      i_rst <= 1'b0;
      rd(`REG_CTRL); `CHK("ctrl reset", 16'h0040, rd_q)
      rd(4'hF); `CHK("unmapped", 16'h0000, rd_q)
      rd(`REG_INT_CLR); `CHK("int clear read", 16'h0000, rd_q)
      wr(`REG_STATUS, 16'hFFFF);
      rd(`REG_STATUS); `CHK("status", {volt, 8'h00}, rd_q)
      $display("test reset done");
      hook(16'h00E4);
      base = t - FAST;
      for (int s = 0; s < 4; s++) begin
         for (int c = 0; c < 4; c++) begin
            hook({8'h00, s[1:0], c[1], 2'b00, c[0], 2'b00});
            `CHK("hook delay", base + cnt_tab[s] + (c[0] ? 0 : 10) + (c[1] ? 0 : 5), t)
         end
      end
      rd(`REG_STATUS); `CHK("path open", 1'b1, rd_q[1])
      `CHK("hook pins", 2'h3, pins)
      wr(`REG_CTRL, 16'h00E4);
      rd(`REG_STATUS); `CHK("path closed", 1'b0, rd_q[1])
      `CHK("hook pins", 2'h0, pins)
      $display("test hook timing done");
      hook(16'h00E4);
      grab(); `CHK("slot data", sample, word)
      `CHK("slot drive", 1'b1, drv_all)
      idle(3);
      rd(`REG_RXDATA); `CHK("rx data", sample, rd_q)
      wr(`REG_CTRL, 16'h00F5);
      grab();
      grab(); `CHK("muted data", 16'h0000, word)
      wr(`REG_CTRL, 16'h00E4);
      grab();
      grab(); `CHK("closed data", 16'h0000, word)
      `CHK("closed drive", 1'b0, drv_any)
      wr(`REG_CTRL, 16'h00EC);
      grab();
      grab(); `CHK("monitor data", sample, word)
      `CHK("monitor drive", 1'b1, drv_all)
      $display("test highway done");
      wr(`REG_INT_EN, 16'h0000);
      rd(`REG_INT_STAT); `CHK("sample event", 16'h0010, rd_q & 16'h0010)
      `CHK("irq masked", 1'b0, o_irq)
      wr(`REG_INT_EN, 16'h0010);
      idle(2);
      #1 `CHK("irq set", 1'b1, o_irq)
      wr(`REG_CTRL, 16'h00E4);
      grab();
      wr(`REG_INT_CLR, 16'h0010);
      idle(2);
      #1 `CHK("irq cleared", 1'b0, o_irq)
      rd(`REG_INT_STAT); `CHK("event cleared", 16'h0000, rd_q & 16'h0010)
      $display("test interrupt done");
      wr(`REG_CTRL, 16'h0042);
      wr(`REG_INT_CLR, 16'h003F);
      idle(1);
      ring_pos <= 1'b1;
      idle(REV + 40);
      rd(`REG_INT_STAT); `CHK("reversal", 16'h0009, rd_q & 16'h000D)
      ring_pos <= 1'b0;
      wr(`REG_INT_CLR, 16'h003F);
      idle(1);
      ring_neg <= 1'b1;
      idle(30);
      ring_pos <= 1'b1;
      idle(REV + 40);
      rd(`REG_INT_STAT); `CHK("ringing", 16'h0006, rd_q & 16'h0006)
      $display("test ring done");
      wr(`REG_LVS_MIN, 16'h0080);
      volt <= 8'h10;
      idle(5);
      rd(`REG_INT_STAT); `CHK("low line", 16'h0020, rd_q & 16'h0020)
      rd(`REG_STATUS); `CHK("line voltage", 8'h10, rd_q[15:8])
      $display("test line voltage done");
      end_of_test();
   end
endmodule
